/* dcsr_map.vh */
// Register offsets, field positions, reset values and timing for the bank
`ifndef DCSR_MAP_VH
`define DCSR_MAP_VH
`define DCSR_A_SLAVE      5'h01
`define DCSR_A_FRONT      5'h02
`define DCSR_A_GPIO_LVL   5'h03
`define DCSR_A_GPIO_DIR   5'h04
`define DCSR_A_ENABLES    5'h05
`define DCSR_A_POLARITY   5'h06
`define DCSR_A_DTEST      5'h07
`define DCSR_A_PSEQ       5'h08
`define DCSR_A_PDIV       5'h09
`define DCSR_A_CPVCO      5'h0A
`define DCSR_A_NDIV       5'h0B
`define DCSR_A_NSEQ       5'h0C
`define DCSR_A_LOCK       5'h0D
`define DCSR_A_CLKF       5'h0E
`define DCSR_A_POWER      5'h0F
`define DCSR_A_CMON       5'h10
`define DCSR_A_IRQ_STAT   5'h11
`define DCSR_A_LS_FIRST   5'h12
`define DCSR_A_IMPED      5'h17
`define DCSR_A_LS_POLLMAX 5'h18
`define DCSR_A_POLLCTL    5'h19
`define DCSR_A_RANGE      5'h1A
`define DCSR_A_LVOLT      5'h1B
`define DCSR_A_LCURR      5'h1C
`define DCSR_A_LSREV      5'h1D
`define DCSR_A_FAULT      5'h1E
`define DCSR_A_POLLVAL    5'h1F
`define DCSR_A_IRQ_MASK   5'h00
// Reset values
`define DCSR_RST_SLAVE    8'h00
`define DCSR_RST_FRONT    8'h00
`define DCSR_RST_GPIO     8'hF0
`define DCSR_RST_DIR      8'hF0
`define DCSR_RST_ENABLES  8'h0B
`define DCSR_RST_PSEQ     8'hDA
`define DCSR_RST_PDIV     8'hEF
`define DCSR_RST_CPVCO    8'h31
`define DCSR_RST_NDIV     8'h2A
`define DCSR_RST_NSEQ     8'h06
`define DCSR_RST_LOCK     8'h42
`define DCSR_RST_POWER    8'h2C
`define DCSR_RST_ZERO     8'h00
`define DCSR_RST_PATH     8'h01
`define DCSR_RST_LOOP     8'h01
// Writable masks of mixed host-side registers
`define DCSR_WM_GPIO_LVL  8'hF0
`define DCSR_WM_GPIO_DIR  8'hF0
`define DCSR_WM_LOCK      8'h3F
`define DCSR_WM_CLKF      8'hBF
// Poll control fields
`define DCSR_POLL_BIT     7
`define DCSR_MATCH_BIT    6
`define DCSR_IDX_HI       3
// Interrupt status bits
`define DCSR_IRQ_POLL     0
`define DCSR_IRQ_MISM     1
`define DCSR_IRQ_FAULT    2
// Line-side write spacing
`define DCSR_LS_GAP_US    300
`define DCSR_CLK_MHZ      20
`define DCSR_LS_GAP_CYC   (`DCSR_LS_GAP_US * `DCSR_CLK_MHZ)
`endif

/* dcsr_regs.v */
// Control and status register bank of the two-part line interface
//
// Behaviour
// - Read-only bits never change on host writes, except the match flag (cleared by a poll start) and CLKF bit 6 (follows POWER).
// - Read/write, write-only and read-only access classes.
// - Line-side registers forwarded across isolation link.
// - Multi-bit fields ordered msb first.
// - Poll fetches indexed line register, flags match.
`timescale 1ns/1ps
`include "dcsr_map.vh"

module dcsr_regs #(
  parameter [15:0] LS_GAP_CYC = `DCSR_LS_GAP_CYC,
  parameter [3:0]  HS_REV     = 4'h1,   // Arbitrary value
  parameter [3:0]  LS_REV     = 4'h2    // Arbitrary value
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       clk_en,
  // Register port
  input  wire [4:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Host-side status inputs from pins
  input  wire [3:0] gpio_in,
  input  wire [3:0] line_status_in,
  input  wire       pll_lock_in,
  input  wire       barrier_sync_in,
  // Line-side link: forward of writes and fetches
  output reg        ls_wr_stb,
  output reg        ls_rd_stb,
  output reg  [4:0] ls_addr,
  output reg  [7:0] ls_wdata,
  input  wire [7:0] ls_rdata,
  input  wire       ls_rdata_vld,
  input  wire [7:0] ls_range_in,
  input  wire [6:0] ls_volt_in,
  input  wire [6:0] ls_curr_in,
  input  wire [4:0] ls_fault_in,
  // Status
  output reg        ls_busy,
  output reg        irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [9:0] sync1_r;
  reg  [9:0] sync2_r;
  wire [3:0] gpio_s    = sync2_r[3:0];
  wire [3:0] lstat_s   = sync2_r[7:4];
  wire       lock_s    = sync2_r[8];
  wire       bsync_s   = sync2_r[9];

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
    end else if (clk_en) begin
      sync1_r <= {barrier_sync_in, pll_lock_in, line_status_in, gpio_in};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function is_line_side;
    input [4:0] a;
    begin
      is_line_side = (a >= `DCSR_A_LS_FIRST);
    end
  endfunction

  // Line-side registers a host write is forwarded to
  function is_ls_writable;
    input [4:0] a;
    begin
      is_ls_writable = (a >= `DCSR_A_LS_FIRST) && (a <= `DCSR_A_POLLCTL);
    end
  endfunction

  // Merge a write into a register leaving read-only bits untouched
  function [7:0] merge_wr;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] wmask;
    begin
      merge_wr = (new_v & wmask) | (old_v & ~wmask);
    end
  endfunction

  wire wr_ok = clk_en && reg_wr;
  wire rd_ok = clk_en && reg_rd;

  // ----------------------------------------------------------------
  // Host-side read/write registers
  // ----------------------------------------------------------------
  reg [7:0] slave_r, front_r, gpio_lvl_r, gpio_dir_r, ena_r, pol_r;
  reg [7:0] dtest_r, pseq_r, pdiv_r, cpvco_r, ndiv_r, nseq_r;
  reg [7:0] lock_r, clkf_r, power_r, cmon_r;
  reg [2:0] irq_mask_r;
  reg [2:0] irq_stat_r;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      slave_r    <= `DCSR_RST_SLAVE;
      front_r    <= `DCSR_RST_FRONT;
      gpio_lvl_r <= `DCSR_RST_GPIO;
      gpio_dir_r <= `DCSR_RST_DIR;
      ena_r      <= `DCSR_RST_ENABLES;
      pol_r      <= `DCSR_RST_ZERO;
      dtest_r    <= `DCSR_RST_ZERO;
      pseq_r     <= `DCSR_RST_PSEQ;
      pdiv_r     <= `DCSR_RST_PDIV;
      cpvco_r    <= `DCSR_RST_CPVCO;
      ndiv_r     <= `DCSR_RST_NDIV;
      nseq_r     <= `DCSR_RST_NSEQ;
      lock_r     <= `DCSR_RST_LOCK;
      clkf_r     <= `DCSR_RST_ZERO;
      power_r    <= `DCSR_RST_POWER;
      cmon_r     <= `DCSR_RST_ZERO;
      irq_mask_r <= 3'h0;
    end else if (wr_ok) begin
      case (reg_addr)
        `DCSR_A_SLAVE:    slave_r    <= reg_wdata;
        `DCSR_A_FRONT:    front_r    <= reg_wdata;
        `DCSR_A_GPIO_LVL: gpio_lvl_r <= merge_wr(gpio_lvl_r, reg_wdata,
                                        `DCSR_WM_GPIO_LVL);
        `DCSR_A_GPIO_DIR: gpio_dir_r <= merge_wr(gpio_dir_r, reg_wdata,
                                        `DCSR_WM_GPIO_DIR);
        `DCSR_A_ENABLES:  ena_r      <= reg_wdata;
        `DCSR_A_POLARITY: pol_r      <= reg_wdata;
        `DCSR_A_DTEST:    dtest_r    <= reg_wdata;
        `DCSR_A_PSEQ:     pseq_r     <= reg_wdata;
        `DCSR_A_PDIV:     pdiv_r     <= reg_wdata;
        `DCSR_A_CPVCO:    cpvco_r    <= reg_wdata;
        `DCSR_A_NDIV:     ndiv_r     <= reg_wdata;
        `DCSR_A_NSEQ:     nseq_r     <= reg_wdata;
        `DCSR_A_LOCK:     lock_r     <= merge_wr(lock_r, reg_wdata,
                                        `DCSR_WM_LOCK);
        `DCSR_A_CLKF:     clkf_r     <= merge_wr(clkf_r, reg_wdata,
                                        `DCSR_WM_CLKF);
        `DCSR_A_POWER:    power_r    <= reg_wdata;
        `DCSR_A_CMON:     cmon_r     <= reg_wdata;
        `DCSR_A_IRQ_MASK: irq_mask_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host-side copies of the line-side registers
  // ----------------------------------------------------------------
  // Write-only values are kept here so the poll can compare against them
  reg [7:0] ls_copy_r [0:7];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_copy
      localparam [4:0] A = `DCSR_A_LS_FIRST + gi;
      always @(posedge sys_clk) begin
        if (sys_rst)
          ls_copy_r[gi] <= (A == 5'h16 || A == 5'h18) ? `DCSR_RST_PATH
                                                      : `DCSR_RST_ZERO;
        else if (wr_ok && reg_addr == A && !ls_busy)
          ls_copy_r[gi] <= reg_wdata;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line-side forwarding and write pacing
  // ----------------------------------------------------------------
  // Writes arriving while the link is paced out are dropped, protecting
  // the line side from a host that ignores the spacing
  reg [15:0] gap_cnt_r;
  reg        poll_pend_r;
  reg        poll_wait_r;
  reg [3:0]  poll_idx_r;
  reg        match_r;
  reg [7:0]  pollval_r;

  wire ls_wr_go = wr_ok && is_ls_writable(reg_addr) && !ls_busy;
  wire poll_go  = ls_wr_go && reg_addr == `DCSR_A_POLLCTL &&
                  reg_wdata[`DCSR_POLL_BIT];
  wire [3:0] idx_w = reg_wdata[`DCSR_IDX_HI:0];
  wire [2:0] cmp_i = poll_idx_r[2:0];
  wire ev_match    = poll_wait_r && ls_rdata_vld &&
                     ls_rdata == ls_copy_r[cmp_i];
  wire ev_mism     = poll_wait_r && ls_rdata_vld && !ev_match;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      gap_cnt_r   <= 16'h0000;
      ls_busy     <= 1'b0;
      ls_wr_stb   <= 1'b0;
      ls_rd_stb   <= 1'b0;
      ls_addr     <= 5'h00;
      ls_wdata    <= 8'h00;
      poll_pend_r <= 1'b0;
      poll_wait_r <= 1'b0;
      poll_idx_r  <= 4'h0;
      match_r     <= 1'b0;
      pollval_r   <= 8'h00;
    end else if (clk_en) begin
      ls_wr_stb <= 1'b0;
      ls_rd_stb <= 1'b0;
      if (ls_wr_go) begin
        ls_wr_stb <= 1'b1;
        ls_addr   <= reg_addr;
        ls_wdata  <= reg_wdata;
        gap_cnt_r <= LS_GAP_CYC - 16'h0001;
        ls_busy   <= 1'b1;
      end else if (gap_cnt_r != 16'h0000) begin
        gap_cnt_r <= gap_cnt_r - 16'h0001;
      end else begin
        ls_busy <= 1'b0;
      end
      if (poll_go) begin
        poll_pend_r <= 1'b1;
        poll_idx_r  <= idx_w;
        match_r     <= 1'b0;
      end else if (poll_pend_r) begin
        poll_pend_r <= 1'b0;
        poll_wait_r <= 1'b1;
        ls_rd_stb   <= 1'b1;
        ls_addr     <= `DCSR_A_LS_FIRST + {1'b0, poll_idx_r};
      end else if (poll_wait_r && ls_rdata_vld) begin
        poll_wait_r <= 1'b0;
        pollval_r   <= ls_rdata;
        match_r     <= ev_match;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  reg        fault_any_r;
  wire       fault_now = |ls_fault_in;
  wire [2:0] ev_w = {fault_now & ~fault_any_r, ev_mism, ev_match};

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat_r  <= 3'h0;
      fault_any_r <= 1'b0;
      irq         <= 1'b0;
    end else if (clk_en) begin
      fault_any_r <= fault_now;
      irq_stat_r  <= (irq_stat_r &
                      ~((wr_ok && reg_addr == `DCSR_A_IRQ_STAT) ?
                        reg_wdata[2:0] : 3'h0)) | ev_w;
      irq         <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  reg [7:0] rd_v;
  always @* begin
    rd_v = 8'h00;
    case (reg_addr)
      `DCSR_A_SLAVE:    rd_v = slave_r;
      `DCSR_A_FRONT:    rd_v = front_r;
      `DCSR_A_GPIO_LVL: rd_v = {gpio_s, lstat_s};
      `DCSR_A_GPIO_DIR: rd_v = {gpio_dir_r[7:4], HS_REV};
      `DCSR_A_ENABLES:  rd_v = ena_r;
      `DCSR_A_POLARITY: rd_v = pol_r;
      `DCSR_A_DTEST:    rd_v = dtest_r;
      `DCSR_A_PSEQ:     rd_v = pseq_r;
      `DCSR_A_PDIV:     rd_v = pdiv_r;
      `DCSR_A_CPVCO:    rd_v = cpvco_r;
      `DCSR_A_NDIV:     rd_v = ndiv_r;
      `DCSR_A_NSEQ:     rd_v = nseq_r;
      `DCSR_A_LOCK:     rd_v = {lock_s, bsync_s, lock_r[5:0]};
      `DCSR_A_CLKF:     rd_v = {clkf_r[7], power_r[6], clkf_r[5:0]};
      `DCSR_A_POWER:    rd_v = power_r;
      `DCSR_A_CMON:     rd_v = cmon_r;
      `DCSR_A_IRQ_STAT: rd_v = {5'h00, irq_stat_r};
      `DCSR_A_IRQ_MASK: rd_v = {5'h00, irq_mask_r};
      // Read/write line-side registers answer from the host-side copy
      `DCSR_A_IMPED:      rd_v = ls_copy_r[5];
      `DCSR_A_LS_POLLMAX: rd_v = ls_copy_r[6];
      `DCSR_A_POLLCTL:  rd_v = {1'b0, match_r, ls_copy_r[7][5:0]};
      `DCSR_A_RANGE:    rd_v = ls_range_in;
      `DCSR_A_LVOLT:    rd_v = {ls_volt_in, 1'b0};
      `DCSR_A_LCURR:    rd_v = {ls_curr_in, 1'b0};
      `DCSR_A_LSREV:    rd_v = {LS_REV, 4'h0};
      `DCSR_A_FAULT:    rd_v = {ls_fault_in, 3'h0};
      `DCSR_A_POLLVAL:  rd_v = pollval_r;
      default:          rd_v = 8'h00; // Write-only and unmapped read zero
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (rd_ok)
      reg_rdata <= rd_v;
  end

endmodule // dcsr_regs

/* dcsr_assertions.sv */
// Concurrent checks on the ports of the register bank
`timescale 1ns/1ps
module dcsr_assertions #(
  parameter [15:0] LS_GAP_CYC = 16'd6000,
  parameter [3:0]  LS_REV     = 4'h2
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Line-side link and status
  input wire logic       ls_wr_stb,
  input wire logic       ls_rd_stb,
  input wire logic [4:0] ls_addr,
  input wire logic [7:0] ls_wdata,
  input wire logic [7:0] ls_range_in,
  input wire logic [6:0] ls_volt_in,
  input wire logic       ls_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Busy span counter
  // ----
  logic [15:0] busy_cnt_r;
  always_ff @(posedge sys_clk)
    busy_cnt_r <= (sys_rst || !ls_busy) ? 16'h0000 : busy_cnt_r + 16'h0001;
  sequence s_ls_host_wr;
    reg_wr && reg_addr inside {[5'h12:5'h19]};
  endsequence
  sequence s_poll_fwd;
    ls_wr_stb && ls_addr == 5'h19 && ls_wdata[7] && !ls_wdata[3];
  endsequence
  // ----
  // Checks
  // ----
  a_line_fwd: assert property (s_ls_host_wr and !ls_busy |=> ls_wr_stb
    && ls_addr == $past(reg_addr) && ls_wdata == $past(reg_wdata))
    else $error("line write not forwarded");
  a_busy_drop: assert property (s_ls_host_wr and ls_busy |=> !ls_wr_stb)
    else $error("line write forwarded while busy");
  a_busy_span: assert property ($fell(ls_busy) |->
    busy_cnt_r >= LS_GAP_CYC && busy_cnt_r <= LS_GAP_CYC + 16'd1)
    else $error("busy span wrong");
  a_wr_spacing: assert property (ls_wr_stb |=> (!ls_wr_stb) [*8])
    else $error("line writes too close");
  a_poll_fetch: assert property (s_poll_fwd |=> ls_rd_stb
    && ls_addr == 5'h12 + 5'($past(ls_wdata) & 8'h07))
    else $error("poll fetch wrong");
  a_range_read: assert property (reg_rd && reg_addr == 5'h1A |=>
    reg_rdata == $past(ls_range_in)) else $error("range read wrong");
  a_volt_order: assert property (reg_rd && reg_addr == 5'h1B |=>
    reg_rdata == {$past(ls_volt_in), 1'b0}) else $error("volt order wrong");
  a_wo_zero: assert property (reg_rd && reg_addr inside {[5'h12:5'h14]}
    |=> reg_rdata == 8'h00) else $error("write-only read not zero");
  a_rev_read: assert property (reg_rd && reg_addr == 5'h1D |=>
    reg_rdata[7:4] == LS_REV) else $error("revision read wrong");
endmodule // dcsr_assertions

/* dcsr_ls_model.sv */
// Line-side part model: register copies and poll answers
`timescale 1ns/1ps
module dcsr_ls_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Link from the bank
  input  wire logic       ls_wr_stb,
  input  wire logic       ls_rd_stb,
  input  wire logic [4:0] ls_addr,
  input  wire logic [7:0] ls_wdata,
  // Scenario controls
  input  wire logic       slow,
  input  wire logic       bad,
  // Answers
  output logic      [7:0] ls_rdata,
  output logic            ls_rdata_vld
);
  logic [7:0] mem [8];
  int         wr_count;
  int         wait_n;
  logic [2:0] idx;
  always @(posedge sys_clk) begin
    ls_rdata_vld <= 1'b0;
    ls_rdata     <= ~ls_rdata; // Stale data never looks valid
    if (sys_rst) begin
      mem      <= '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
      wr_count <= 0;
      wait_n   <= 0;
      ls_rdata <= 8'h5A;
    end else begin
      if (ls_wr_stb && ls_addr < 5'h19)
        mem[ls_addr[2:0] - 3'h2] <= ls_wdata;
      if (ls_wr_stb)
        wr_count <= wr_count + 1;
      if (ls_rd_stb) begin
        idx    <= ls_addr[2:0] - 3'h2;
        wait_n <= slow ? 6 : 1;
      end else if (wait_n == 1) begin
        ls_rdata_vld <= 1'b1;
        ls_rdata     <= bad ? ~mem[idx] : mem[idx];
        wait_n       <= 0;
      end else if (wait_n > 1)
        wait_n <= wait_n - 1;
    end
  end
endmodule // dcsr_ls_model

/* testbench.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
module testbench;
  logic       sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, bad = 1'b0;
  logic [4:0] reg_addr = 5'h00, ls_fault_in = 5'h00;
  logic [7:0] reg_wdata = 8'h00, ls_range_in = 8'h00, q, d;
  logic [3:0] gpio_in = 4'h0, line_status_in = 4'h0;
  logic       pll_lock_in = 1'b0, barrier_sync_in = 1'b0;
  logic [6:0] ls_volt_in = 7'h00, ls_curr_in = 7'h00;
  wire  [7:0] reg_rdata, ls_wdata, ls_rdata;
  wire  [4:0] ls_addr;
  wire        ls_wr_stb, ls_rd_stb, ls_rdata_vld, ls_busy, irq;
  int         err_total = 0, n_checks = 0, n0;
  logic [7:0] model [32];
  logic [4:0] ra [13] = '{5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A,
                          5'h0B, 5'h0C, 5'h0F, 5'h10, 5'h17, 5'h18};
  logic [7:0] rv [13] = '{8'h00, 8'h0B, 8'h00, 8'h00, 8'hDA, 8'hEF, 8'h31,
                          8'h2A, 8'h06, 8'h2C, 8'h00, 8'h00, 8'h01};
  logic [4:0] rw [4] = '{5'h05, 5'h08, 5'h09, 5'h0C};
  logic [4:0] pidx [3] = '{5'h05, 5'h06, 5'h00};
  initial forever #25 sys_clk = ~sys_clk;
  dcsr_regs #(.LS_GAP_CYC(16'd20)) u_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .line_status_in(line_status_in), .pll_lock_in(pll_lock_in),
    .barrier_sync_in(barrier_sync_in), .ls_wr_stb(ls_wr_stb),
    .ls_rd_stb(ls_rd_stb), .ls_addr(ls_addr), .ls_wdata(ls_wdata),
    .ls_rdata(ls_rdata), .ls_rdata_vld(ls_rdata_vld),
    .ls_range_in(ls_range_in), .ls_volt_in(ls_volt_in),
    .ls_curr_in(ls_curr_in), .ls_fault_in(ls_fault_in),
    .ls_busy(ls_busy), .irq(irq));
  dcsr_ls_model u_ls (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .ls_wr_stb(ls_wr_stb), .ls_rd_stb(ls_rd_stb), .ls_addr(ls_addr),
    .ls_wdata(ls_wdata), .slow(slow), .bad(bad), .ls_rdata(ls_rdata),
    .ls_rdata_vld(ls_rdata_vld));
  // ----
  // Bus and compare tasks
  // ----
  task chk(input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input w, input r, input [4:0] a, input [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= v;
  endtask
  task wr(input [4:0] a, input [7:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, v);
  endtask
  task rd(input [4:0] a, output [7:0] v);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 v = reg_rdata;
  endtask
  // Bounded wait: for a fetch answer, or for the write spacing to end
  task wait_for(input bit vld);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while ((vld ? ls_rdata_vld !== 1'b1 : ls_busy !== 1'b0) && k < 200);
    if (k >= 200) err_total++;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    q = $urandom(20);
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], q);
      chk(q, rv[i]);
      model[ra[i]] = rv[i];
    end
    foreach (rw[i]) begin
      d = $urandom;
      bus(1'b1, 1'b0, rw[i], d);
      rd(rw[i], q);
      chk(q, d);
    end
    @(posedge sys_clk);
    {gpio_in, line_status_in, ls_range_in} <= $urandom;
    {pll_lock_in, barrier_sync_in, ls_volt_in, ls_curr_in,
     ls_fault_in} <= $urandom;
    wr(5'h03, 8'h0F);
    wr(5'h1A, 8'hFF);
    rd(5'h03, q);
    chk(q, {gpio_in, line_status_in});
    rd(5'h0D, q);
    chk(q & 8'hC0, {pll_lock_in, barrier_sync_in, 6'h00});
    rd(5'h1A, q);
    chk(q, ls_range_in);
    rd(5'h1C, q);
    chk(q, {ls_curr_in, 1'b0});
    rd(5'h1E, q);
    chk(q, {ls_fault_in, 3'h0});
    wait_for(1'b0);
    n0 = u_ls.wr_count;
    d = $urandom & 8'h98;
    wr(5'h17, d);
    model[5'h17] = d;
    bus(1'b1, 1'b0, 5'h18, 8'hF0);
    bus(1'b0, 1'b0, 5'h18, 8'hF0);
    #1 chk(8'(u_ls.wr_count - n0), 8'h01);
    chk(u_ls.mem[5], d);
    rd(5'h17, q);
    chk(q, d);
    rd(5'h18, q);
    chk(q, 8'h01);
    wait_for(1'b0);
    d = $urandom;
    wr(5'h12, d);
    model[5'h12] = d;
    rd(5'h12, q);
    chk(q, 8'h00);
    for (int m = 0; m < 3; m++) begin
      slow = (m == 1);
      bad = (m == 2);
      wait_for(1'b0);
      wr(5'h00, bad ? 8'h01 : 8'h03);
      wr(5'h11, 8'h07);
      wr(5'h19, 8'h80 | pidx[m]);
      wait_for(1'b1);
      rd(5'h1F, q);
      chk(q, model[5'h12 + pidx[m]] ^ {8{bad}});
      rd(5'h19, q);
      chk(q & 8'hDF, {1'b0, !bad, 2'b00, pidx[m][3:0]});
      rd(5'h11, q);
      chk(q, bad ? 8'h02 : 8'h01);
      chk({7'h00, irq}, {7'h00, !bad});
      wr(5'h11, 8'h07);
      repeat (2) @(posedge sys_clk);
      #1 chk({7'h00, irq}, 8'h00);
    end
    stop_test;
  end
  initial begin
    #500000;
    err_total++;
    stop_test;
  end
endmodule // testbench
bind dcsr_regs dcsr_assertions #(.LS_GAP_CYC(LS_GAP_CYC), .LS_REV(LS_REV))
  u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ls_wr_stb(ls_wr_stb), .ls_rd_stb(ls_rd_stb),
  .ls_addr(ls_addr), .ls_wdata(ls_wdata), .ls_range_in(ls_range_in),
  .ls_volt_in(ls_volt_in), .ls_busy(ls_busy));
